// ===== astf_regs.svh
// Purpose: constants of the serial transmit framing block
// Assumes: included by its bare name
// Notes: phase and sample counts are in 16x oversample ticks, frame lengths in bits
// Operation
// (R1) Full duplex NRZ on separate pins
// (R2) Independent transmit and receive baud rates
// (R3) Word length eight or nine bits
// (R4) Idle, start, data LSB first, stop
// (R5) Start bit low, stop bit high
// (R6) Enabled idle transmitter holds line high
// (R7) Both disabled releases output pin
// (R8) Idle character is full frame of ones
// (R9) Break zeros, then one extra mark bit
// (R10) Ninth bit taken from ninth-bit control
// (R11) Enable sends idle frame before data
// (R12) Empty flag cleared by status, write
// (R13) Empty flag set when holding moves on
// (R14) Empty flag interrupt when enabled, unmasked
// (R15) Busy write fills holding, moves at end
// (R16) Idle write loads shifter, sets empty
// (R17) Complete flag after stop or break
// (R18) Complete flag cleared like empty flag
// (R19) Receiver oversamples input against noise
// (R20) Five interrupt sources with own flags
// (R21) Overrun, noise, framing, parity error flags
// (R22) Separate transmitter and receiver enables
// (R23) Mute with address or idle wake-up
// (R24) Break frames repeat while break set
// (R25) Rate is clock over 16, prescale, divider
// (R26) Enable toggle inserts idle, loses holding
// (R27) Full flag cleared by status, read
// (R28) Reset: disabled, empty and complete set
`ifndef ASTF_REGS_SVH
`define ASTF_REGS_SVH
`define ASTF_PR_1 11'h001
`define ASTF_PR_3 11'h003
`define ASTF_PR_4 11'h004
`define ASTF_PR_13 11'h00D
`define ASTF_PH_LAST 4'hF
`define ASTF_SMP_A 4'h7
`define ASTF_SMP_B 4'h8
`define ASTF_SMP_C 4'h9
`define ASTF_BITS_8 4'hA
`define ASTF_BITS_9 4'hB
`define ASTF_RST_TX_BUFFER_EMPTY_FLAG 1'h1
`define ASTF_RST_TC 1'h1
`endif

// ===== astf_pkg.sv
// Purpose: types of the serial transmit framing block
// Assumes: nothing
// Notes: none
package astf_pkg;
   typedef enum {TX_OFF, TX_IDLE, TX_FRAME} astf_tx_state_t;
   typedef enum {RX_OFF, RX_HUNT, RX_START, RX_DATA, RX_STOP}
      astf_rx_state_t;
   typedef enum {FR_DATA, FR_IDLE, FR_BREAK, FR_MARK} astf_frame_t;
endpackage

// ===== astf_baud_if.sv
// Purpose: rate selection and tick between top and divider
// Assumes: one clock
// Notes: none
`timescale 1ns/1ns
interface astf_baud_if;
   logic [1:0] presc;
   logic [2:0] rate;
   logic tick;
   modport ctrl (output presc, output rate, input tick);
   modport gen (input presc, input rate, output tick);
endinterface

// ===== astf_baud.sv
// Purpose: 16x oversample tick from prescaler and divider
// Assumes: selections stable while the link is enabled
// Notes: tick is one clock wide, but stays high on every clock at prescale 1 and rate 0
`timescale 1ns/1ns
`include "astf_regs.svh"
module astf_baud (
   // Clock and reset
   input logic clk,
   input logic sys_rst,
   // Rate selection and tick
   astf_baud_if.gen bd
);
   import astf_pkg::*;
   logic [10:0] cnt_r;
   logic [10:0] cnt_nxt;
   logic [10:0] pr;
   logic [10:0] limit;
   logic tick_r;
   logic tick_nxt;

   // (R25) prescale times power-of-two divider
   always_comb begin
      case (bd.presc)
         2'h0: pr = `ASTF_PR_1;
         2'h1: pr = `ASTF_PR_3;
         2'h2: pr = `ASTF_PR_4;
         default: pr = `ASTF_PR_13;
      endcase
      limit = 11'((pr << bd.rate) - 11'h001);
      tick_nxt = 1'h0;
      cnt_nxt = 11'(cnt_r + 11'h001);
      if (cnt_r >= limit) begin
         cnt_nxt = 11'h000;
         tick_nxt = 1'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cnt_r <= 11'h000;
         tick_r <= 1'h0;
      end else begin
         cnt_r <= cnt_nxt;
         tick_r <= tick_nxt;
      end
   end

   assign bd.tick = tick_r;
endmodule

// ===== astf_top.sv
// Purpose: asynchronous serial transmitter, receiver and flags
// Assumes: control bits and access strobes come from clk logic
// Notes: only the serial input pin is synchronised
`timescale 1ns/1ns
`include "astf_regs.svh"
module astf_top (
   // Clock and reset
   input logic clk,
   input logic sys_rst,
   // Configuration
   input logic tx_enable,
   input logic rx_enable,
   input logic word_len_nine,
   input logic parity_en,
   input logic parity_odd,
   input logic tx_ninth_bit,
   input logic send_break_ctrl,
   input logic rx_wake_addr,
   input logic rx_mute_set,
   input logic [1:0] baud_prescale_sel,
   input logic [2:0] tx_rate_sel,
   input logic [2:0] rx_rate_sel,
   // Interrupt control
   input logic tx_empty_irq_en,
   input logic tx_complete_irq_en,
   input logic rx_full_irq_en,
   input logic idle_irq_en,
   input logic cpu_irq_mask,
   // CPU accesses
   input logic status_access,
   input logic data_write,
   input logic data_read,
   input logic [7:0] data_wdata,
   // Serial pins
   input logic serial_in_pin,
   output logic serial_out,
   output logic serial_out_oe,
   // Status
   output logic tx_buffer_empty_flag,
   output logic tx_complete_flag,
   output logic rx_full_flag,
   output logic idle_flag,
   output logic overrun_flag,
   output logic noise_flag,
   output logic framing_flag,
   output logic parity_flag,
   output logic rx_mute,
   output logic irq,
   output logic [7:0] rx_data,
   output logic rx_ninth_bit
);
   import astf_pkg::*;

   // ****************************************
   // Baud generators
   // ****************************************
   astf_baud_if tx_bd ();
   astf_baud_if rx_bd ();
   // (R2) separate dividers per direction
   assign tx_bd.presc = baud_prescale_sel;
   assign tx_bd.rate = tx_rate_sel;
   assign rx_bd.presc = baud_prescale_sel;
   assign rx_bd.rate = rx_rate_sel;
   astf_baud u_tx_baud (.clk(clk), .sys_rst(sys_rst), .bd(tx_bd));
   astf_baud u_rx_baud (.clk(clk), .sys_rst(sys_rst), .bd(rx_bd));

   function automatic logic [10:0] astf_build(input logic [8:0] d,
      input logic nine, input logic pe, input logic po);
      logic [8:0] w;
      begin
         w = d;
         if (pe && nine)
            w[8] = (^d[7:0]) ^ po;
         if (pe && !nine)
            w[7] = (^d[6:0]) ^ po;
         // (R4) start, data LSB first, stop
         if (nine)
            astf_build = {1'h1, w, 1'h0};
         else
            astf_build = {2'h3, w[7:0], 1'h0};
      end
   endfunction

   // ****************************************
   // Transmitter
   // ****************************************
   astf_tx_state_t tx_st_r, tx_st_nxt;
   astf_frame_t kind_r, kind_nxt;
   logic [10:0] sh_r, sh_nxt;
   logic [3:0] nb_r, nb_nxt;
   logic [3:0] ph_r, ph_nxt;
   logic [8:0] hold_r, hold_nxt;
   logic hold_full_r, hold_full_nxt;
   logic idle_pend_r, idle_pend_nxt;
   logic brk_r, brk_nxt;
   logic te_q_r;
   logic out_r, out_nxt;
   logic oe_r, oe_nxt;
   logic [3:0] fbits;
   logic te_rise, te_fall, frame_end, ready;
   logic tx_buffer_empty_flag_set, tc_set, load_data;

   always_comb begin
      tx_st_nxt = tx_st_r;
      kind_nxt = kind_r;
      sh_nxt = sh_r;
      nb_nxt = nb_r;
      ph_nxt = ph_r;
      hold_nxt = hold_r;
      hold_full_nxt = hold_full_r;
      idle_pend_nxt = idle_pend_r;
      brk_nxt = brk_r;
      tx_buffer_empty_flag_set = 1'h0;
      tc_set = 1'h0;
      load_data = 1'h0;
      // (R3) frame length from word length
      fbits = word_len_nine ? `ASTF_BITS_9 : `ASTF_BITS_8;
      te_rise = tx_enable && !te_q_r;
      te_fall = !tx_enable && te_q_r;
      frame_end = tx_st_r == TX_FRAME && tx_bd.tick &&
         ph_r == `ASTF_PH_LAST && nb_r == 4'h1;
      ready = tx_st_r == TX_IDLE || frame_end;
      if (tx_st_r == TX_FRAME && tx_bd.tick) begin
         ph_nxt = 4'(ph_r + 4'h1);
         if (ph_r == `ASTF_PH_LAST) begin
            sh_nxt = {1'h1, sh_r[10:1]};
            nb_nxt = 4'(nb_r - 4'h1);
         end
      end
      // (R11) enable edge queues an idle frame
      if (te_rise)
         idle_pend_nxt = 1'h1;
      // (R15) write lands in the holding buffer
      // (R10) ninth bit captured with the data
      if (data_write) begin
         hold_nxt = {tx_ninth_bit, data_wdata};
         hold_full_nxt = 1'h1;
      end
      // (R26) enable drop loses holding data
      if (te_fall)
         hold_full_nxt = 1'h0;
      // (R17) complete after data or break frame
      if (frame_end && (kind_r == FR_DATA || kind_r == FR_BREAK))
         tc_set = 1'h1;
      if (tx_st_r == TX_OFF) begin
         if (tx_enable)
            tx_st_nxt = TX_IDLE;
      end else if (ready) begin
         ph_nxt = 4'h0;
         nb_nxt = fbits;
         tx_st_nxt = TX_FRAME;
         if (!tx_enable) begin
            tx_st_nxt = TX_OFF;
         end else if (idle_pend_r || te_rise) begin
            // (R8) idle frame is all ones
            kind_nxt = FR_IDLE;
            sh_nxt = 11'h7FF;
            idle_pend_nxt = 1'h0;
         end else if (send_break_ctrl) begin
            // (R24) break frames repeat while set
            kind_nxt = FR_BREAK;
            sh_nxt = 11'h000;
            brk_nxt = 1'h1;
         end else if (brk_r) begin
            // (R9) one mark bit after the break
            kind_nxt = FR_MARK;
            sh_nxt = 11'h7FF;
            nb_nxt = 4'h1;
            brk_nxt = 1'h0;
         end else if (hold_full_nxt) begin
            // (R13) (R16) holding moves on, empty set
            kind_nxt = FR_DATA;
            sh_nxt = astf_build(hold_nxt, word_len_nine, parity_en,
               parity_odd);
            hold_full_nxt = 1'h0;
            tx_buffer_empty_flag_set = 1'h1;
            load_data = 1'h1;
         end else begin
            tx_st_nxt = TX_IDLE;
         end
      end
      // (R7) release only when both are disabled
      oe_nxt = tx_st_nxt != TX_OFF || rx_enable;
      // (R5) (R6) shifter drives, otherwise high
      out_nxt = tx_st_nxt == TX_FRAME ? sh_nxt[0] : 1'h1;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         tx_st_r <= TX_OFF;
         kind_r <= FR_IDLE;
         sh_r <= 11'h7FF;
         nb_r <= 4'h0;
         ph_r <= 4'h0;
         hold_r <= 9'h000;
         hold_full_r <= 1'h0;
         idle_pend_r <= 1'h0;
         brk_r <= 1'h0;
         te_q_r <= 1'h0;
         out_r <= 1'h1;
         oe_r <= 1'h0;
      end else begin
         tx_st_r <= tx_st_nxt;
         kind_r <= kind_nxt;
         sh_r <= sh_nxt;
         nb_r <= nb_nxt;
         ph_r <= ph_nxt;
         hold_r <= hold_nxt;
         hold_full_r <= hold_full_nxt;
         idle_pend_r <= idle_pend_nxt;
         brk_r <= brk_nxt;
         te_q_r <= tx_enable;
         out_r <= out_nxt;
         oe_r <= oe_nxt;
      end
   end

   // ****************************************
   // Receiver
   // ****************************************
   astf_rx_state_t rx_st_r, rx_st_nxt;
   logic rin_m_r, rin_s_r;
   logic [3:0] rph_r, rph_nxt;
   logic [3:0] rb_r, rb_nxt;
   logic [2:0] smp_r, smp_nxt;
   logic [8:0] rsh_r, rsh_nxt;
   logic [8:0] rdat_r, rdat_nxt;
   logic [7:0] ict_r, ict_nxt;
   logic noisy_r, noisy_nxt;
   logic iarm_r, iarm_nxt;
   logic mute_r, mute_nxt;
   logic rx_full_flag_r;
   logic rbit, rnoise, rdone, idle_ev;
   logic [8:0] word;
   logic rx_full_flag_set, or_set, idle_set, nf_set, fe_set, pe_set;

   always_comb begin
      rx_st_nxt = rx_st_r;
      rph_nxt = rph_r;
      rb_nxt = rb_r;
      smp_nxt = smp_r;
      rsh_nxt = rsh_r;
      rdat_nxt = rdat_r;
      ict_nxt = ict_r;
      noisy_nxt = noisy_r;
      iarm_nxt = iarm_r;
      mute_nxt = mute_r;
      rx_full_flag_set = 1'h0;
      or_set = 1'h0;
      idle_set = 1'h0;
      nf_set = 1'h0;
      fe_set = 1'h0;
      pe_set = 1'h0;
      rdone = 1'h0;
      idle_ev = 1'h0;
      // (R19) majority of three mid-bit samples
      rbit = (smp_r[0] & smp_r[1]) | (smp_r[0] & smp_r[2]) |
         (smp_r[1] & smp_r[2]);
      rnoise = smp_r != 3'h0 && smp_r != 3'h7;
      word = word_len_nine ? rsh_r : {1'h0, rsh_r[8:1]};
      if (rx_mute_set)
         mute_nxt = 1'h1;
      if (rx_st_r != RX_OFF && rx_st_r != RX_HUNT && rx_bd.tick) begin
         rph_nxt = 4'(rph_r + 4'h1);
         if (rph_r == `ASTF_SMP_A)
            smp_nxt[0] = rin_s_r;
         if (rph_r == `ASTF_SMP_B)
            smp_nxt[1] = rin_s_r;
         if (rph_r == `ASTF_SMP_C)
            smp_nxt[2] = rin_s_r;
      end
      case (rx_st_r)
         RX_OFF: begin
            if (rx_enable) begin
               rx_st_nxt = RX_HUNT;
               iarm_nxt = 1'h0;
               ict_nxt = 8'h00;
            end
         end
         RX_HUNT: begin
            if (rx_bd.tick && !rin_s_r) begin
               rx_st_nxt = RX_START;
               rph_nxt = 4'h1;
               noisy_nxt = 1'h0;
               ict_nxt = 8'h00;
            end else if (rx_bd.tick && iarm_r) begin
               ict_nxt = 8'(ict_r + 8'h01);
               if (ict_r == {fbits, 4'h0}) begin
                  idle_ev = 1'h1;
                  iarm_nxt = 1'h0;
               end
            end
         end
         RX_START: begin
            if (rx_bd.tick && rph_r == `ASTF_PH_LAST) begin
               rx_st_nxt = rbit ? RX_HUNT : RX_DATA;
               rb_nxt = 4'h0;
               noisy_nxt = rnoise;
            end
         end
         RX_DATA: begin
            if (rx_bd.tick && rph_r == `ASTF_PH_LAST) begin
               rsh_nxt = {rbit, rsh_r[8:1]};
               noisy_nxt = noisy_r | rnoise;
               rb_nxt = 4'(rb_r + 4'h1);
               if (rb_r == 4'(fbits - 4'h3))
                  rx_st_nxt = RX_STOP;
            end
         end
         RX_STOP: begin
            if (rx_bd.tick && rph_r == `ASTF_PH_LAST) begin
               rdone = 1'h1;
               rx_st_nxt = RX_HUNT;
               iarm_nxt = 1'h1;
               ict_nxt = 8'h00;
            end
         end
         default: rx_st_nxt = RX_OFF;
      endcase
      // (R23) address mark wakes and is received
      if (rdone && mute_r && rx_wake_addr &&
         (word_len_nine ? word[8] : word[7]))
         mute_nxt = 1'h0;
      // (R21) (R27) overrun keeps the old data
      if (rdone && (!mute_r || !mute_nxt)) begin
         if (rx_full_flag_r) begin
            or_set = 1'h1;
         end else begin
            rdat_nxt = word;
            rx_full_flag_set = 1'h1;
            nf_set = noisy_r | rnoise;
            fe_set = !rbit;
            pe_set = parity_en &&
               (((word_len_nine ? ^word : ^word[7:0])) ^ parity_odd);
         end
      end
      // (R23) idle wake clears mute without flag
      if (idle_ev) begin
         if (!mute_r)
            idle_set = 1'h1;
         else if (!rx_wake_addr)
            mute_nxt = 1'h0;
      end
      // (R22) receiver has its own enable
      if (!rx_enable)
         rx_st_nxt = RX_OFF;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rx_st_r <= RX_OFF;
         rin_m_r <= 1'h1;
         rin_s_r <= 1'h1;
         rph_r <= 4'h0;
         rb_r <= 4'h0;
         smp_r <= 3'h7;
         rsh_r <= 9'h000;
         rdat_r <= 9'h000;
         ict_r <= 8'h00;
         noisy_r <= 1'h0;
         iarm_r <= 1'h0;
         mute_r <= 1'h0;
      end else begin
         rx_st_r <= rx_st_nxt;
         rin_m_r <= serial_in_pin;
         rin_s_r <= rin_m_r;
         rph_r <= rph_nxt;
         rb_r <= rb_nxt;
         smp_r <= smp_nxt;
         rsh_r <= rsh_nxt;
         rdat_r <= rdat_nxt;
         ict_r <= ict_nxt;
         noisy_r <= noisy_nxt;
         iarm_r <= iarm_nxt;
         mute_r <= mute_nxt;
      end
   end

   // ****************************************
   // Flags and interrupt
   // ****************************************
   logic armed_r, armed_nxt;
   logic tx_buffer_empty_flag_r, tx_buffer_empty_flag_nxt, tc_r, tc_nxt;
   logic rx_full_flag_nxt;
   logic [4:0] err_r, err_nxt;
   logic irq_r, irq_nxt;
   logic clr_tx, clr_rx;

   always_comb begin
      armed_nxt = armed_r;
      if (data_write || data_read)
         armed_nxt = 1'h0;
      if (status_access)
         armed_nxt = 1'h1;
      // (R12) (R18) status access, then data write
      clr_tx = armed_r && data_write;
      clr_rx = armed_r && data_read;
      tx_buffer_empty_flag_nxt = tx_buffer_empty_flag_set || (tx_buffer_empty_flag_r && !clr_tx);
      tc_nxt = tc_set || (tc_r && !clr_tx);
      // (R27) status access, then data read
      rx_full_flag_nxt = rx_full_flag_set || (rx_full_flag_r && !clr_rx);
      err_nxt = {idle_set, or_set, nf_set, fe_set, pe_set} |
         (err_r & {5{!clr_rx}});
      // (R14) (R20) five sources, global mask
      irq_nxt = !cpu_irq_mask && ((tx_buffer_empty_flag_r && tx_empty_irq_en) ||
         (tc_r && tx_complete_irq_en) ||
         ((rx_full_flag_r || err_r[3]) && rx_full_irq_en) ||
         (err_r[4] && idle_irq_en));
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         // (R28) empty and complete set after reset
         armed_r <= 1'h0;
         tx_buffer_empty_flag_r <= `ASTF_RST_TX_BUFFER_EMPTY_FLAG;
         tc_r <= `ASTF_RST_TC;
         rx_full_flag_r <= 1'h0;
         err_r <= 5'h00;
         irq_r <= 1'h0;
      end else begin
         armed_r <= armed_nxt;
         tx_buffer_empty_flag_r <= tx_buffer_empty_flag_nxt;
         tc_r <= tc_nxt;
         rx_full_flag_r <= rx_full_flag_nxt;
         err_r <= err_nxt;
         irq_r <= irq_nxt;
      end
   end

   // (R1) both directions run concurrently
   assign serial_out = out_r;
   assign serial_out_oe = oe_r;
   assign tx_buffer_empty_flag = tx_buffer_empty_flag_r;
   assign tx_complete_flag = tc_r;
   assign rx_full_flag = rx_full_flag_r;
   assign idle_flag = err_r[4];
   assign overrun_flag = err_r[3];
   assign noise_flag = err_r[2];
   assign framing_flag = err_r[1];
   assign parity_flag = err_r[0];
   assign rx_mute = mute_r;
   assign irq = irq_r;
   assign rx_data = rdat_r[7:0];
   assign rx_ninth_bit = rdat_r[8];

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   chk_start_low: assert property (load_data |=> !out_r) // R5
      else $error("start bit not low");
   chk_stop_high: assert property ( // R5
      tx_st_r == TX_FRAME && kind_r == FR_DATA && nb_r == 4'h1
      |-> out_r) else $error("stop bit not high");
   chk_idle_high: assert property ( // R6
      tx_st_r == TX_IDLE && tx_st_nxt == TX_IDLE |=> out_r && oe_r)
      else $error("idle line not high");
   chk_pin_release: assert property ( // R7
      tx_st_r == TX_OFF && !tx_enable && !rx_enable |=> !oe_r)
      else $error("pin not released");
   chk_idle_first: assert property ( // R11
      tx_st_r == TX_OFF && te_rise ##1 tx_enable
      |=> tx_st_r == TX_FRAME && kind_r == FR_IDLE)
      else $error("no idle frame after enable");
   chk_tx_buffer_empty_flag_clear: assert property ( // R12
      clr_tx && !tx_buffer_empty_flag_set |=> !tx_buffer_empty_flag_r)
      else $error("empty flag not cleared");
   chk_tx_buffer_empty_flag_keep: assert property ( // R12
      tx_buffer_empty_flag_r && !armed_r && !status_access ##1 !armed_r |-> tx_buffer_empty_flag_r)
      else $error("empty flag cleared without status");
   chk_direct_load: assert property ( // R16
      tx_st_r == TX_IDLE && tx_enable && data_write && !idle_pend_r &&
      !send_break_ctrl && !brk_r |=> tx_st_r == TX_FRAME && tx_buffer_empty_flag_r)
      else $error("direct load failed");
   chk_tc_set: assert property ( // R17
      frame_end && kind_r == FR_DATA |=> tc_r)
      else $error("complete flag not set");
   chk_ninth_bit: assert property ( // R10
      load_data && word_len_nine && !parity_en && !data_write
      |=> sh_r[9] == $past(hold_r[8]))
      else $error("ninth bit wrong");
   chk_irq_mask: assert property (cpu_irq_mask |=> !irq_r) // R14
      else $error("interrupt while masked");
   chk_rx_full_flag_clear: assert property ( // R27
      clr_rx && !rx_full_flag_set |=> !rx_full_flag_r)
      else $error("full flag not cleared");

   cov_data_frame: cover property (frame_end && kind_r == FR_DATA);
   cov_break_mark: cover property (tx_st_r == TX_FRAME &&
      kind_r == FR_MARK);
   cov_overrun: cover property (or_set);
   cov_idle_rx: cover property (idle_set);
endmodule

// ===== astf_remote.sv
// Purpose: remote serial transceiver beside the block
// Assumes: 16 clk cycles per bit
// Notes: line idles high between frames
`timescale 1ns/1ns
module astf_remote (
   // Clock
   input wire logic clk,
   // Serial lines
   input wire logic line_in,
   output logic line_out
);
   logic [8:0] got;
   logic stop_seen;
   initial begin
      line_out = 1'h1;
   end
   // start low, LSB first, stop high
   task automatic grab(input int n);
      int i;
      i = 0;
      while (line_in !== 1'h0 && i < 4000) begin
         @(posedge clk);
         i++;
      end
      repeat (8) @(posedge clk);
      got = 9'h000;
      for (i = 0; i < n; i++) begin
         repeat (16) @(posedge clk);
         got[i] = line_in;
      end
      repeat (16) @(posedge clk);
      stop_seen = line_in;
   endtask
   task automatic send(input logic [7:0] w);
      int i;
      line_out <= 1'h0;
      repeat (16) @(posedge clk);
      for (i = 0; i < 8; i++) begin
         line_out <= w[i];
         repeat (16) @(posedge clk);
      end
      line_out <= 1'h1;
      repeat (16) @(posedge clk);
   endtask
endmodule

// ===== astf_top_tb.sv
// Purpose: self-checking bench of the serial block
// Assumes: fastest rate, 16 clk cycles per bit
// Notes: txs packs oe, line, empty and complete
`timescale 1ns/1ns
module astf_top_tb;
   logic clk = 1'h0;
   logic sys_rst = 1'h1;
   logic tx_enable = 1'h0, rx_enable = 1'h0, word_len_nine = 1'h0;
   logic parity_en = 1'h0, parity_odd = 1'h0, tx_ninth_bit = 1'h0;
   logic send_break_ctrl = 1'h0, rx_wake_addr = 1'h0, rx_mute_set = 1'h0;
   logic [1:0] baud_prescale_sel = 2'h0;
   logic [2:0] tx_rate_sel = 3'h0, rx_rate_sel = 3'h0;
   logic tx_empty_irq_en = 1'h0, tx_complete_irq_en = 1'h0;
   logic rx_full_irq_en = 1'h0, idle_irq_en = 1'h0, cpu_irq_mask = 1'h1;
   logic status_access = 1'h0, data_write = 1'h0, data_read = 1'h0;
   logic [7:0] data_wdata = 8'h00;
   logic serial_in_pin, serial_out, serial_out_oe, tx_buffer_empty_flag;
   logic tx_complete_flag, rx_full_flag, idle_flag, overrun_flag;
   logic noise_flag, framing_flag, parity_flag, rx_mute, irq;
   logic [7:0] rx_data;
   logic rx_ninth_bit;
   logic [3:0] txs;
   int num_errors = 0, total_checks = 0, n, i;
   assign txs = {serial_out_oe, serial_out, tx_buffer_empty_flag,
      tx_complete_flag};
   astf_top uut (.clk, .sys_rst, .tx_enable, .rx_enable, .word_len_nine,
      .parity_en, .parity_odd, .tx_ninth_bit, .send_break_ctrl,
      .rx_wake_addr, .rx_mute_set, .baud_prescale_sel, .tx_rate_sel,
      .rx_rate_sel, .tx_empty_irq_en, .tx_complete_irq_en, .rx_full_irq_en,
      .idle_irq_en, .cpu_irq_mask, .status_access, .data_write, .data_read,
      .data_wdata, .serial_in_pin, .serial_out, .serial_out_oe,
      .tx_buffer_empty_flag, .tx_complete_flag, .rx_full_flag, .idle_flag,
      .overrun_flag, .noise_flag, .framing_flag, .parity_flag, .rx_mute,
      .irq, .rx_data, .rx_ninth_bit);
   astf_remote rm (.clk(clk), .line_in(serial_out), .line_out(serial_in_pin));
   initial begin
      forever #25 clk = ~clk;
   end
   // ****************
   // Access tasks
   // ****************
   task automatic chk(input string nm, input logic [8:0] e, logic [8:0] g);
      total_checks++;
      if (g !== e) begin
         num_errors++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic acc(input logic sa, input logic w, input logic [7:0] d);
      @(posedge clk);
      status_access <= sa;
      @(posedge clk);
      status_access <= 1'h0;
      data_write <= w;
      data_read <= !w;
      data_wdata <= d;
      @(posedge clk);
      data_write <= 1'h0;
      data_read <= 1'h0;
      #1;
   endtask
   task automatic wait_set(ref logic s);
      for (int k = 0; k < 4000 && s !== 1'h1; k++) begin
         @(posedge clk);
         #1;
      end
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // ****************
   // Tests
   // ****************
   initial begin
      repeat (3) @(posedge clk);
      sys_rst <= 1'h0;
      @(posedge clk);
      #1;
      chk("txs", 9'h007, {5'h00, txs});
      $display("test reset done");
      @(posedge clk);
      tx_enable <= 1'h1;
      repeat (2) @(posedge clk);
      #1;
      chk("txs", 9'h00F, {5'h00, txs});
      acc(1'h1, 1'h1, 8'hA5);
      chk("txs", 9'h00C, {5'h00, txs});
      rm.grab(8);
      chk("word", 9'h0A5, rm.got);
      chk("stop", 9'h001, {8'h00, rm.stop_seen});
      wait_set(tx_complete_flag);
      chk("txs", 9'h00F, {5'h00, txs});
      $display("test first word done");
      acc(1'h1, 1'h1, 8'h3C);
      chk("txs", 9'h00A, {5'h00, txs});
      acc(1'h0, 1'h1, 8'hC3);
      chk("txs", 9'h00A, {5'h00, txs});
      rm.grab(8);
      chk("word", 9'h03C, rm.got);
      rm.grab(8);
      chk("word", 9'h0C3, rm.got);
      $display("test back to back done");
      @(posedge clk);
      word_len_nine <= 1'h1;
      tx_ninth_bit <= 1'h1;
      acc(1'h1, 1'h1, 8'h5A);
      rm.grab(9);
      chk("word", 9'h15A, rm.got);
      wait_set(tx_complete_flag);
      $display("test nine bits done");
      @(posedge clk);
      send_break_ctrl <= 1'h1;
      n = 0;
      for (i = 0; i < 2000; i++) begin
         @(posedge clk);
         #1;
         if (serial_out === 1'h0)
            n++;
         else if (n > 0)
            break;
         if (n == 100)
            send_break_ctrl <= 1'h0;
      end
      chk("break", 9'h0B0, n[8:0]);
      chk("txs", 9'h00F, {5'h00, txs});
      $display("test break done");
      @(posedge clk);
      word_len_nine <= 1'h0;
      rx_enable <= 1'h1;
      fork
         rm.send(8'h96);
         begin
            acc(1'h1, 1'h1, 8'h69);
            rm.grab(8);
         end
      join
      chk("word", 9'h069, rm.got);
      wait_set(rx_full_flag);
      chk("rx", 9'h196, {rx_full_flag, rx_data});
      acc(1'h1, 1'h0, 8'h00);
      chk("rx", 9'h096, {rx_full_flag, rx_data});
      $display("test duplex done");
      @(posedge clk);
      tx_empty_irq_en <= 1'h1;
      tx_complete_irq_en <= 1'h1;
      rx_full_irq_en <= 1'h1;
      idle_irq_en <= 1'h1;
      repeat (3) @(posedge clk);
      #1;
      chk("irq", 9'h000, {8'h00, irq});
      @(posedge clk);
      cpu_irq_mask <= 1'h0;
      repeat (3) @(posedge clk);
      #1;
      chk("irq", 9'h001, {8'h00, irq});
      $display("test irq done");
      @(posedge clk);
      tx_enable <= 1'h0;
      rx_enable <= 1'h0;
      repeat (400) @(posedge clk);
      #1;
      chk("txs", 9'h007, {5'h00, txs});
      $display("test release done");
      complete_run();
   end
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      complete_run();
   end
endmodule
